// >>> hdl/reflex_output_selector.sv
`timescale 1ns/10ps
module reflex_output_selector #(
  parameter int unsigned HOLD_CYCLES = reflex_output_pkg::SC_HOLD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire reflex_output_pkg::meter_s meter,
  input wire logic short_detect,
  input wire logic cpu_control,
  input wire logic module_running,
  output logic phys_out,
  output logic output_state_bit,
  output logic fault_active
);
  import reflex_output_pkg::*;

  localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);

  // -------------------------------------------------------------------------
  // register storage
  // -------------------------------------------------------------------------
  logic [CTL_W-1:0] ctrl;
  logic [3:0] func_code;
  logic [31:0] lower_lim;
  logic [31:0] upper_lim;
  logic [31:0] pulse_duration_param;
  logic [15:0] scale_div;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic cmp_less;
  logic cmp_window;
  logic cmp_great;
  logic cond_prev;
  logic [31:0] pulse_cnt;
  logic [15:0] scale_cnt;
  logic scale_out;
  fault_e fault_state;
  fault_e next_fault_state;
  logic [31:0] hold_cnt;

  // -------------------------------------------------------------------------
  // ahb-lite decode
  // -------------------------------------------------------------------------
  // zero wait states: every transfer completes in its first data cycle
  wire addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire wr_take = addr_take && hwrite;
  wire rd_take = addr_take && !hwrite;
  wire [7:0] a_ofs = haddr[7:0];
  wire a_high_zero = (haddr[31:8] == ZERO32[31:8]);

  wire reflex_en = ctrl[CTL_REFLEX_EN];
  wire cmd_out = ctrl[CTL_CMD_OUT];
  wire cmp_en = ctrl[CTL_CMP_EN];
  wire cmp_susp = ctrl[CTL_CMP_SUSP];
  wire pol_neg = ctrl[CTL_POL_NEG];
  wire autorec = ctrl[CTL_AUTORECOVER];
  wire fb_en = ctrl[CTL_FB_EN];
  wire fb_val = ctrl[CTL_FB_VAL];

  wire [31:0] status_word = {26'h000_0000, phys_out, cmp_great, cmp_window, cmp_less,
                             fault_active, output_state_bit};

  // read mux; unmapped offsets read zero
  wire [31:0] rd_word =
      !a_high_zero ? ZERO32 :
      (a_ofs == OFS_CTRL) ? {24'h00_0000, ctrl} :
      (a_ofs == OFS_FUNC) ? {28'h000_0000, func_code} :
      (a_ofs == OFS_LOWER) ? lower_lim :
      (a_ofs == OFS_UPPER) ? upper_lim :
      (a_ofs == OFS_PULSE) ? pulse_duration_param :
      (a_ofs == OFS_SCALE) ? {16'h0000, scale_div} :
      (a_ofs == OFS_STATUS) ? status_word : ZERO32;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= ZERO32;
    end else begin
      wr_pend <= wr_take && a_high_zero;
      wr_addr <= a_ofs;
      hrdata <= rd_take ? rd_word : hrdata;
    end
  end

  // -------------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------------
  // codes above the last defined one are dropped to keep the selector legal
  wire func_ok = (hwdata[3:0] <= FN_SCALE);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
      func_code <= FN_NONE;
      lower_lim <= ZERO32;
      upper_lim <= ZERO32;
      pulse_duration_param <= ZERO32;
      scale_div <= ONE16;
    end else if (wr_pend) begin
      if (wr_addr == OFS_CTRL) ctrl <= hwdata[CTL_W-1:0];
      if (wr_addr == OFS_FUNC && func_ok) func_code <= hwdata[3:0];
      if (wr_addr == OFS_LOWER) lower_lim <= hwdata;
      if (wr_addr == OFS_UPPER) upper_lim <= hwdata;
      if (wr_addr == OFS_PULSE) pulse_duration_param <= hwdata;
      if (wr_addr == OFS_SCALE) scale_div <= hwdata[15:0];
    end
  end

  // -------------------------------------------------------------------------
  // compare function
  // -------------------------------------------------------------------------
  // a bad limit pair keeps its stored lower value but it takes no part
  wire lower_valid = (upper_lim > lower_lim);
  wire new_less = lower_valid && (meter.freq < lower_lim);
  wire new_great = (meter.freq > upper_lim);
  wire new_window = (lower_valid ? (meter.freq >= lower_lim) : 1'b1) && !new_great;

  // status forced to zero when disabled, frozen while suspended
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_less <= 1'b0;
      cmp_window <= 1'b0;
      cmp_great <= 1'b0;
    end else if (!cmp_en) begin
      cmp_less <= 1'b0;
      cmp_window <= 1'b0;
      cmp_great <= 1'b0;
    end else if (meter.refresh && !cmp_susp) begin
      cmp_less <= new_less;
      cmp_window <= new_window;
      cmp_great <= new_great;
    end
  end

  // -------------------------------------------------------------------------
  // timed pulse for codes 7 to 9
  // -------------------------------------------------------------------------
  wire pulse_cond = (func_code == FN_P_LESS) ? cmp_less :
                    (func_code == FN_P_WINDOW) ? cmp_window :
                    (func_code == FN_P_GREAT) ? cmp_great : 1'b0;
  wire pulse_start = pulse_cond && !cond_prev;
  wire [31:0] next_pulse_cnt = pulse_start ? pulse_duration_param :
                               (pulse_cnt != ZERO32) ? pulse_cnt - 32'h0000_0001 : ZERO32;
  wire pulse_active = (pulse_cnt != ZERO32);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_prev <= 1'b0;
      pulse_cnt <= ZERO32;
    end else begin
      cond_prev <= pulse_cond;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // -------------------------------------------------------------------------
  // scaling pulse divider
  // -------------------------------------------------------------------------
  // square wave toggling every scale_div ticks; a factor of one or zero gives none
  wire scale_live = (scale_div > ONE16);
  wire scale_wrap = (scale_cnt >= scale_div - ONE16);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scale_cnt <= 16'h0000;
      scale_out <= 1'b0;
    end else if (!scale_live) begin
      scale_cnt <= 16'h0000;
      scale_out <= 1'b0;
    end else if (meter.scale_tick) begin
      scale_cnt <= scale_wrap ? 16'h0000 : scale_cnt + ONE16;
      scale_out <= scale_wrap ? !scale_out : scale_out;
    end
  end

  // -------------------------------------------------------------------------
  // function result and logical output
  // -------------------------------------------------------------------------
  logic fn_result;
  always_comb begin
    fn_result = 1'b0;
    case (func_code)
      FN_LESS: fn_result = cmp_less;
      FN_WINDOW: fn_result = cmp_window;
      FN_GREAT: fn_result = cmp_great;
      FN_STOPPED: fn_result = meter.stopped;
      FN_UNDER: fn_result = meter.under;
      FN_OVER: fn_result = meter.over;
      FN_P_LESS, FN_P_WINDOW, FN_P_GREAT: fn_result = pulse_active;
      FN_SCALE: fn_result = scale_out;
      default: fn_result = 1'b0;
    endcase
  end

  // lost control with fallback wins; without fallback registers just keep running
  wire fb_force = !cpu_control && fb_en;
  wire next_logic = fb_force ? fb_val :
                    (reflex_en ? fn_result : cmd_out);
  // a stopped module cannot invert, so the driver stays positive
  wire neg_active = pol_neg && module_running;
  wire next_demand = next_logic ^ neg_active;
  wire fault_now = short_detect || (fault_state == F_HOLD);
  wire next_phys = next_demand && !fault_now;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_state_bit <= 1'b0;
      phys_out <= 1'b0;
    end else begin
      output_state_bit <= next_logic;
      phys_out <= next_phys;
    end
  end

  // -------------------------------------------------------------------------
  // short-circuit supervisor
  // -------------------------------------------------------------------------
  // a fresh short restarts the wait, so a new event always beats the clear
  wire hold_done = (hold_cnt == HOLD_LAST);
  wire latched_clear = !short_detect && !reflex_en && !next_demand;
  wire auto_clear = !short_detect;
  wire may_clear = hold_done && (autorec ? auto_clear : latched_clear);

  always_comb begin
    next_fault_state = fault_state;
    unique case (fault_state)
      F_OK: next_fault_state = short_detect ? F_HOLD : F_OK;
      F_HOLD: next_fault_state = may_clear ? F_OK : F_HOLD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_state <= F_OK;
      hold_cnt <= ZERO32;
      fault_active <= 1'b0;
    end else begin
      fault_state <= next_fault_state;
      hold_cnt <= (fault_state == F_OK || short_detect) ? ZERO32 :
                  hold_done ? hold_cnt : hold_cnt + 32'h0000_0001;
      fault_active <= (next_fault_state == F_HOLD);
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  property p_cmd_path;
    @(posedge hclk) disable iff (!hresetn)
      (cpu_control && !reflex_en) |=> (output_state_bit == $past(cmd_out));
  endproperty
  a_cmd_path: assert property (p_cmd_path) else $error("command bit not on output");

  property p_less;
    @(posedge hclk) disable iff (!hresetn)
      (cpu_control && reflex_en && func_code == FN_LESS)
        |=> (output_state_bit == $past(cmp_less));
  endproperty
  a_less: assert property (p_less) else $error("less result not on output");

  property p_window_excl;
    @(posedge hclk) disable iff (!hresetn)
      !(cmp_window && (cmp_less || cmp_great));
  endproperty
  a_window_excl: assert property (p_window_excl) else $error("window overlaps");

  property p_stopped;
    @(posedge hclk) disable iff (!hresetn)
      (cpu_control && reflex_en && func_code == FN_STOPPED)
        |=> (output_state_bit == $past(meter.stopped));
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped not on output");

  property p_short_off;
    @(posedge hclk) disable iff (!hresetn)
      short_detect |=> !phys_out ##1 !phys_out;
  endproperty
  a_short_off: assert property (p_short_off) else $error("output on during short");

  property p_hold_min;
    @(posedge hclk) disable iff (!hresetn)
      (fault_state == F_HOLD && hold_cnt != HOLD_LAST) |=> fault_active;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("fault cleared too early");

  property p_polarity;
    @(posedge hclk) disable iff (!hresetn)
      (!fault_now && $stable(pol_neg)) |=>
        (phys_out == (output_state_bit ^ $past(pol_neg && module_running)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_fallback;
    @(posedge hclk) disable iff (!hresetn)
      (!cpu_control && fb_en) |=> (output_state_bit == $past(fb_val));
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback value not forced");

  property p_cmp_off;
    @(posedge hclk) disable iff (!hresetn)
      !cmp_en |=> !(cmp_less || cmp_window || cmp_great);
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("compare not zero");

  property p_no_scale;
    @(posedge hclk) disable iff (!hresetn)
      !scale_live |=> !scale_out;
  endproperty
  a_no_scale: assert property (p_no_scale) else $error("scale pulse with factor one");

  property p_window;
    @(posedge hclk) disable iff (!hresetn)
      (cpu_control && reflex_en && func_code == FN_WINDOW)
        |=> (output_state_bit == $past(cmp_window));
  endproperty
  a_window: assert property (p_window) else $error("window result not on output");

  property p_great;
    @(posedge hclk) disable iff (!hresetn)
      (cpu_control && reflex_en && func_code == FN_GREAT)
        |=> (output_state_bit == $past(cmp_great));
  endproperty
  a_great: assert property (p_great) else $error("great result not on output");

  property p_scale_path;
    @(posedge hclk) disable iff (!hresetn)
      (cpu_control && reflex_en && func_code == FN_SCALE)
        |=> (output_state_bit == $past(scale_out));
  endproperty
  a_scale_path: assert property (p_scale_path) else $error("scale pulse not on output");

  property p_pulse_load;
    @(posedge hclk) disable iff (!hresetn)
      pulse_start |=> (pulse_cnt == $past(pulse_duration_param));
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("pulse not started");

endmodule : reflex_output_selector

// >>> hdl/reflex_output_pkg.sv
package reflex_output_pkg;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SC_HOLD_S = 10;
  // least time, exact in whole cycles at this clock rate
  localparam int unsigned SC_HOLD_CYC = SC_HOLD_S * CLK_HZ;

  // -------------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FUNC = 8'h04;
  localparam logic [7:0] OFS_LOWER = 8'h08;
  localparam logic [7:0] OFS_UPPER = 8'h0C;
  localparam logic [7:0] OFS_PULSE = 8'h10;
  localparam logic [7:0] OFS_SCALE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // -------------------------------------------------------------------------
  // control register field positions and reset value
  // -------------------------------------------------------------------------
  localparam int CTL_REFLEX_EN = 0;
  localparam int CTL_CMD_OUT = 1;
  localparam int CTL_CMP_EN = 2;
  localparam int CTL_CMP_SUSP = 3;
  localparam int CTL_POL_NEG = 4;
  localparam int CTL_AUTORECOVER = 5;
  localparam int CTL_FB_EN = 6;
  localparam int CTL_FB_VAL = 7;
  localparam int CTL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h40;

  // -------------------------------------------------------------------------
  // function codes
  // -------------------------------------------------------------------------
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_LESS = 4'h1;
  localparam logic [3:0] FN_WINDOW = 4'h2;
  localparam logic [3:0] FN_GREAT = 4'h3;
  localparam logic [3:0] FN_STOPPED = 4'h4;
  localparam logic [3:0] FN_UNDER = 4'h5;
  localparam logic [3:0] FN_OVER = 4'h6;
  localparam logic [3:0] FN_P_LESS = 4'h7;
  localparam logic [3:0] FN_P_WINDOW = 4'h8;
  localparam logic [3:0] FN_P_GREAT = 4'h9;
  localparam logic [3:0] FN_SCALE = 4'hA;

  // -------------------------------------------------------------------------
  // misc constants
  // -------------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ONE16 = 16'h0001;

  // fault supervisor states
  typedef enum logic [1:0] {
    F_OK = 2'b01,
    F_HOLD = 2'b10
  } fault_e;

  // frequency meter side of the block
  typedef struct packed {
    logic [31:0] freq;       // measured value
    logic refresh;           // one-cycle strobe, new freq valid
    logic stopped;           // no input frequency
    logic under;             // too slow
    logic over;              // too fast
    logic scale_tick;        // one-cycle strobe per scaled input pulse
  } meter_s;

endpackage : reflex_output_pkg

// >>> tb/reflex_meter_model.sv
`timescale 1ns/10ps
// ------
// meter and output driver model
// ------
module reflex_meter_model (
  input wire logic hclk,
  output reflex_output_pkg::meter_s meter,
  output logic short_detect
);
  import reflex_output_pkg::*;
  // quiet at time zero: no strobes, all levels low
  initial begin
    meter = '0;
    short_detect = 1'b0;
  end
  // one refresh strobe with a new value
  task automatic refresh(input logic [31:0] f);
    meter.freq <= f;
    meter.refresh <= 1'b1;
    @(posedge hclk);
    meter.refresh <= 1'b0;
  endtask : refresh
  // stopped, under and over are plain levels
  task automatic levels(input logic [2:0] v);
    {meter.over, meter.under, meter.stopped} <= v;
    @(posedge hclk);
  endtask : levels
  // ticks one cycle wide, three apart, so no two strobes merge
  task automatic ticks(input int n);
    repeat (n) begin
      meter.scale_tick <= 1'b1;
      @(posedge hclk);
      meter.scale_tick <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask : ticks
  // driver reports a short for n cycles
  task automatic short_pulse(input int n);
    short_detect <= 1'b1;
    repeat (n) @(posedge hclk);
    short_detect <= 1'b0;
  endtask : short_pulse
endmodule : reflex_meter_model

// >>> tb/reflex_output_selector_tb_top.sv
`timescale 1ns/10ps
module reflex_output_selector_tb_top;
  import reflex_output_pkg::*;
  // ------
  // setup
  // ------
  localparam int HOLD = 20;
  localparam int RE = 1 << CTL_REFLEX_EN;
  localparam int CM = 1 << CTL_CMD_OUT;
  localparam int CE = 1 << CTL_CMP_EN;
  localparam int SU = 1 << CTL_CMP_SUSP;
  localparam int NG = 1 << CTL_POL_NEG;
  localparam int AU = 1 << CTL_AUTORECOVER;
  localparam int FE = 1 << CTL_FB_EN;
  localparam int FV = 1 << CTL_FB_VAL;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] hsize = 3'h2;
  logic cpu_control = 1'b1;
  logic module_running = 1'b1;
  logic hreadyout, hresp, phys_out, output_state_bit, fault_active, short_detect;
  logic [31:0] hrdata, rd, lo, up, f;
  logic [2:0] e;
  meter_s meter;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int hi, tg, pw;

  always #25 hclk = ~hclk;

  reflex_output_selector #(.HOLD_CYCLES(HOLD)) uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .meter, .short_detect,
    .cpu_control, .module_running, .phys_out, .output_state_bit, .fault_active
  );
  reflex_meter_model pm (.hclk, .meter, .short_detect);

  // ------
  // helpers
  // ------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask : bus
  // high cycles and changes of the logical output over n cycles
  task automatic watch(input int n);
    logic p;
    hi = 0;
    tg = 0;
    p = output_state_bit;
    repeat (n) begin
      @(posedge hclk);
      hi += (output_state_bit === 1'b1);
      tg += (output_state_bit !== p);
      p = output_state_bit;
    end
  endtask : watch
  task automatic out_chk(input int c, input logic cpu, run, s, p);
    bus(OFS_CTRL, c, 1'b1);
    cpu_control <= cpu;
    module_running <= run;
    repeat (3) @(posedge hclk);
    chk("state bit", s, output_state_bit);
    chk("phys out", p, phys_out);
  endtask : out_chk
  // {great, window, less}; lower limit drops out when upper is not above it
  function automatic logic [2:0] cmp(input logic [31:0] f, lo, up);
    if (up <= lo) return {f > up, f <= up, 1'b0};
    return {f > up, f >= lo && f <= up, f < lo};
  endfunction : cmp

  // a hang ends the run as a failure
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end

  // ------
  // scenarios
  // ------
  initial begin
    void'($urandom(32'h84c1_8bf0));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(OFS_CTRL, 0, 0);
    chk("ctrl reset", 32'h0000_0040, rd);
    bus(OFS_FUNC, 0, 0);
    chk("func reset", 0, rd);
    bus(8'h40, 32'hFFFF_FFFF, 1);
    bus(8'h40, 0, 0);
    chk("unmapped", 0, rd);
    bus(OFS_FUNC, 5, 1);
    bus(OFS_FUNC, $urandom_range(15, 11), 1);
    bus(OFS_FUNC, 0, 0);
    chk("func kept", 5, rd);
    for (int i = 0; i < 8; i++) begin
      out_chk(CM * i[0] + NG * i[1], 1'b1, i[2], i[0], i[0] ^ (i[1] & i[2]));
    end
    out_chk(CM + FE, 1'b0, 1'b1, 1'b0, 1'b0);
    out_chk(FE + FV, 1'b0, 1'b1, 1'b1, 1'b1);
    out_chk(CM, 1'b0, 1'b1, 1'b1, 1'b1);
    for (int c = 4; c <= 6; c++) begin
      bus(OFS_FUNC, c, 1);
      for (int v = 1; v >= 0; v--) begin
        pm.levels(3'(v ? 1 << (c - 4) : 7 ^ (1 << (c - 4))));
        out_chk(RE + FE, 1'b1, 1'b1, v[0], v[0]);
      end
    end
    pm.levels(3'h0);
    bus(OFS_CTRL, RE + CE + FE, 1);
    for (int c = 1; c <= 3; c++) begin
      bus(OFS_FUNC, c, 1);
      for (int i = 0; i < 8; i++) begin
        lo = $urandom_range(200);
        up = (i == 0) ? lo : $urandom_range(200);
        f = (i < 3) ? ((i == 1) ? lo : up) : $urandom_range(200);
        bus(OFS_LOWER, lo, 1);
        bus(OFS_UPPER, up, 1);
        pm.refresh(f);
        repeat (3) @(posedge hclk);
        e = cmp(f, lo, up);
        chk("logic out", e[c-1], output_state_bit);
        bus(OFS_STATUS, 0, 0);
        chk("status", e, rd[4:2]);
        bus(OFS_LOWER, 0, 0);
        chk("lower kept", lo, rd);
      end
    end
    bus(OFS_CTRL, RE + CE + SU + FE, 1);
    pm.refresh(~f);
    repeat (3) @(posedge hclk);
    bus(OFS_STATUS, 0, 0);
    chk("held", e, rd[4:2]);
    bus(OFS_CTRL, RE + FE, 1);
    // the forced zero lands one edge after the write, so let it settle first
    @(posedge hclk);
    bus(OFS_STATUS, 0, 0);
    chk("disabled", 0, rd[4:2]);
    bus(OFS_LOWER, 100, 1);
    bus(OFS_UPPER, 200, 1);
    bus(OFS_CTRL, RE + CE + FE, 1);
    for (int c = 7; c <= 9; c++) begin
      pw = $urandom_range(9, 2);
      bus(OFS_FUNC, c, 1);
      bus(OFS_PULSE, pw, 1);
      pm.refresh(c == 8 ? 300 : 150);
      repeat (4) @(posedge hclk);
      fork
        watch(30);
        pm.refresh(50 + 100 * (c - 7));
      join
      chk("pulse length", pw, hi);
    end
    bus(OFS_FUNC, FN_SCALE, 1);
    for (int s = 1; s <= 3; s++) begin
      bus(OFS_SCALE, s, 1);
      fork
        watch(170);
        pm.ticks(40);
      join
      chk("scale toggles", 1, s == 1 ? tg == 0 : tg >= 40 / s - 1 && tg <= 40 / s + 1);
    end
    bus(OFS_FUNC, FN_NONE, 1);
    out_chk(CM + AU + FE, 1'b1, 1'b1, 1'b1, 1'b1);
    pm.short_pulse(3);
    chk("short off", 0, phys_out);
    hi = 0;
    while (fault_active === 1'b1 && hi < 100) begin
      @(posedge hclk);
      hi++;
    end
    chk("hold time", 1, hi >= HOLD - 2 && hi <= HOLD + 3);
    repeat (2) @(posedge hclk);
    chk("recovered", 1, phys_out);
    out_chk(CM + FE, 1'b1, 1'b1, 1'b1, 1'b1);
    pm.short_pulse(3);
    repeat (HOLD + 10) @(posedge hclk);
    chk("latched off", 0, phys_out);
    chk("fault held", 1, fault_active);
    // reflex off and output commanded inactive clears the latched fault
    out_chk(FE, 1'b1, 1'b1, 1'b0, 1'b0);
    chk("fault cleared", 0, fault_active);
    out_chk(CM + FE, 1'b1, 1'b1, 1'b1, 1'b1);
    final_report();
  end
endmodule : reflex_output_selector_tb_top
